// file: hdl/filter_sync_pkg.sv
// Shared constants for the decimation filter and conversion control block.
// Assumes a single 40 MHz APB clock domain driving every stage.
`default_nettype none

package filter_sync_pkg;

  localparam int DW = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_HPCOEF = 8'h04;
  localparam logic [7:0] ADDR_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // Field positions
  localparam int CTL_PATH_LSB = 0;
  localparam int CTL_RATE_LSB = 2;
  localparam int CTL_PHASE_BIT = 5;
  localparam int CTL_CONT_BIT = 6;
  localparam int CMD_SYNC_BIT = 0;
  localparam int CMD_RESET_BIT = 1;
  localparam int ST_SETTLE_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_FORCE_BIT = 2;
  localparam int ST_ARMED_BIT = 3;
  localparam int ST_LEFT_LSB = 8;

  typedef enum logic [1:0] {
    PATH_BYPASS = 2'b00,
    PATH_SINC = 2'b01,
    PATH_FIR = 2'b10,
    PATH_FIR_HPF = 2'b11
  } path_t;

  // Reset values and the largest legal rate code
  localparam logic [1:0] PATH_RESET = 2'b10;
  localparam logic [2:0] RATE_RESET = 3'b010;
  localparam logic [2:0] RATE_MAX_CODE = 3'b100;
  localparam logic PHASE_RESET = 1'b0;
  localparam logic CONT_RESET = 1'b0;
  localparam logic [15:0] HPCOEF_RESET = 16'h0337;

  // Rates and counts
  localparam int MOD_DIV = 4;
  localparam int SINC_MAX_DECIM = 128;
  localparam int FIR_DECIM = 32;
  localparam int FIR_STAGES = 4;
  localparam int FIR_RATIO [FIR_STAGES] = '{2, 2, 4, 2};
  localparam int FIR_PHASED_FROM = 2;
  localparam int HPF_FRAC_BITS = 16;
  localparam logic [5:0] SETTLE_READINGS = 6'h3F;
  localparam logic [2:0] READY_HIGH_CYCLES = 3'h4;

endpackage : filter_sync_pkg

`default_nettype wire

// file: hdl/decim_fir_stage.sv
// One decimating FIR sub-stage with a linear and a minimum phase tap set.
// Assumes in_valid pulses no faster than one sample per clock.
`default_nettype none

module decim_fir_stage #(
  parameter int RATIO = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic min_phase,
  // Sample stream
  input wire logic in_valid,
  input wire logic [filter_sync_pkg::DW-1:0] in_data,
  output logic out_valid,
  output logic [filter_sync_pkg::DW-1:0] out_data
);

  localparam int TAPS = 2 * RATIO;
  localparam int AW = 48;

  typedef struct packed {
    logic [TAPS-1:0][filter_sync_pkg::DW-1:0] taps;
    logic [3:0] cnt;
    logic ov;
    logic [filter_sync_pkg::DW-1:0] od;
  } fir_state_t;

  // Both sets sum to 2**(TAPS-1), so DC gain is exact after the shift
  function automatic logic [7:0] coef(input int k, input logic minp);
    int c;
    c = 1;
    if (minp)
    begin
      c = (k == TAPS - 1) ? 1 : (1 << (TAPS - 2 - k));
    end
    else
    begin
      for (int i = 0; i < k; i++)
      begin
        c = c * (TAPS - 1 - i) / (i + 1);
      end
    end
    return 8'(c);
  endfunction : coef

  fir_state_t r;
  fir_state_t n;

  always_comb
  begin
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] cf;
    acc = '0;
    cf = '0;
    n = r;
    n.ov = 1'b0;
    if (clear)
    begin
      n = '0;
    end
    else if (in_valid)
    begin
      n.taps = {r.taps[TAPS-2:0], in_data};
      if (r.cnt == 4'(RATIO - 1))
      begin
        n.cnt = '0;
        for (int k = 0; k < TAPS; k++)
        begin
          cf = AW'(coef(k, min_phase));
          acc = acc + AW'(signed'(n.taps[k])) * cf;
        end
        n.od = filter_sync_pkg::DW'(acc >>> (TAPS - 1));
        n.ov = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign out_valid = r.ov;
  assign out_data = r.od;

endmodule : decim_fir_stage

`default_nettype wire

// file: hdl/highpass_iir.sv
// First-order recursive high-pass: y = x - x1 + y1 - y1*coef/65536.
// Assumes the coefficient is held steady while samples flow.
`default_nettype none

module highpass_iir (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic [15:0] coef,
  // Sample stream
  input wire logic in_valid,
  input wire logic [filter_sync_pkg::DW-1:0] in_data,
  output logic out_valid,
  output logic [filter_sync_pkg::DW-1:0] out_data
);

  typedef struct packed {
    logic [filter_sync_pkg::DW-1:0] xp;
    logic [filter_sync_pkg::DW-1:0] yp;
    logic ov;
  } hp_state_t;

  hp_state_t r;
  hp_state_t n;

  always_comb
  begin
    logic signed [63:0] y;
    y = '0;
    n = r;
    n.ov = 1'b0;
    if (clear)
    begin
      n = '0;
    end
    else if (in_valid)
    begin
      // Wide accumulate keeps the pole product from wrapping
      y = 64'(signed'(in_data)) - 64'(signed'(r.xp)) + 64'(signed'(r.yp))
        - ((64'(signed'(r.yp)) * 64'(signed'({1'b0, coef}))) >>> filter_sync_pkg::HPF_FRAC_BITS);
      n.xp = in_data;
      n.yp = filter_sync_pkg::DW'(y);
      n.ov = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign out_valid = r.ov;
  assign out_data = r.yp;

endmodule : highpass_iir

`default_nettype wire

// file: hdl/decimation_filter_sync_control.sv
// FIR decimator, high-pass stage, sync and reset control with APB registers.
// Assumes sinc samples and the modulator bit arrive on pclk; sync pin is async.
`default_nettype none

module decimation_filter_sync_control (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator and sinc stage
  input wire logic mod_bit,
  input wire logic sinc_valid,
  input wire logic [31:0] sinc_data,
  output logic mod_strobe,
  output logic [2:0] sinc_rate,
  // Sync pin
  input wire logic sync_pin,
  // Conversion output
  output logic [31:0] conv_data,
  output logic conv_valid,
  output logic conversion_ready_n,
  output logic dout_force_low
);

  typedef struct packed {
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic [1:0] path;
    logic [2:0] rate;
    logic phase_min;
    logic cont;
    logic [15:0] hpcoef;
    logic sync_cmd;
    logic reset_cmd;
    logic armed;
    logic [15:0] phase_cnt;
    logic [15:0] last_phase;
    logic [5:0] settle;
    logic [2:0] high_cnt;
    logic clear;
    logic [1:0] mod_cnt;
    logic mod_strobe;
    logic [31:0] conv_data;
    logic conv_valid;
    logic ready_n;
    logic force_low;
    logic [31:0] prdata;
  } ctl_state_t;

  localparam ctl_state_t RESET_STATE = '{
    path: filter_sync_pkg::PATH_RESET,
    rate: filter_sync_pkg::RATE_RESET,
    phase_min: filter_sync_pkg::PHASE_RESET,
    cont: filter_sync_pkg::CONT_RESET,
    hpcoef: filter_sync_pkg::HPCOEF_RESET,
    settle: filter_sync_pkg::SETTLE_READINGS,
    ready_n: 1'b1,
    default: '0
  };

  ctl_state_t r;
  ctl_state_t n;

  logic stg_valid [0:filter_sync_pkg::FIR_STAGES];
  logic [31:0] stg_data [0:filter_sync_pkg::FIR_STAGES];
  logic hp_valid;
  logic [31:0] hp_data;

  // Sub-stage chain; later stages follow the phase selection
  assign stg_valid[0] = sinc_valid;
  assign stg_data[0] = sinc_data;

  genvar gi;
  generate
    for (gi = 0; gi < filter_sync_pkg::FIR_STAGES; gi++)
    begin : g_fir
      localparam bit PHASED = gi >= filter_sync_pkg::FIR_PHASED_FROM;
      decim_fir_stage #(
        .RATIO(filter_sync_pkg::FIR_RATIO[gi])
      ) u_stage (
        .pclk(pclk),
        .presetn(presetn),
        .clear(r.clear),
        .min_phase(PHASED ? r.phase_min : 1'b0),
        .in_valid(stg_valid[gi]),
        .in_data(stg_data[gi]),
        .out_valid(stg_valid[gi+1]),
        .out_data(stg_data[gi+1])
      );
    end
  endgenerate

  highpass_iir u_highpass (
    .pclk(pclk),
    .presetn(presetn),
    .clear(r.clear),
    .coef(r.hpcoef),
    .in_valid(stg_valid[filter_sync_pkg::FIR_STAGES]),
    .in_data(stg_data[filter_sync_pkg::FIR_STAGES]),
    .out_valid(hp_valid),
    .out_data(hp_data)
  );

  logic sel_valid;
  logic [31:0] sel_data;
  logic [15:0] period;
  logic mapped;
  logic [31:0] rd_word;

  // Source selection and output period in clocks
  always_comb
  begin
    sel_valid = 1'b0;
    sel_data = '0;
    period = 16'(filter_sync_pkg::MOD_DIV);
    case (r.path)
      filter_sync_pkg::PATH_BYPASS:
      begin
        sel_valid = r.mod_strobe;
        sel_data = {31'h0, mod_bit};
      end
      filter_sync_pkg::PATH_SINC:
      begin
        sel_valid = sinc_valid;
        sel_data = sinc_data;
        period = 16'(filter_sync_pkg::MOD_DIV * (filter_sync_pkg::SINC_MAX_DECIM >> r.rate));
      end
      filter_sync_pkg::PATH_FIR:
      begin
        sel_valid = stg_valid[filter_sync_pkg::FIR_STAGES];
        sel_data = stg_data[filter_sync_pkg::FIR_STAGES];
        period = 16'(filter_sync_pkg::MOD_DIV * filter_sync_pkg::FIR_DECIM
          * (filter_sync_pkg::SINC_MAX_DECIM >> r.rate));
      end
      default:
      begin
        sel_valid = hp_valid;
        sel_data = hp_data;
        period = 16'(filter_sync_pkg::MOD_DIV * filter_sync_pkg::FIR_DECIM
          * (filter_sync_pkg::SINC_MAX_DECIM >> r.rate));
      end
    endcase
  end

  // Address decode and read word
  always_comb
  begin
    mapped = 1'b1;
    rd_word = '0;
    if (paddr == filter_sync_pkg::ADDR_CONTROL)
    begin
      rd_word[filter_sync_pkg::CTL_PATH_LSB +: 2] = r.path;
      rd_word[filter_sync_pkg::CTL_RATE_LSB +: 3] = r.rate;
      rd_word[filter_sync_pkg::CTL_PHASE_BIT] = r.phase_min;
      rd_word[filter_sync_pkg::CTL_CONT_BIT] = r.cont;
    end
    else if (paddr == filter_sync_pkg::ADDR_HPCOEF)
    begin
      rd_word[15:0] = r.hpcoef;
    end
    else if (paddr == filter_sync_pkg::ADDR_COMMAND)
    begin
      rd_word = '0;
    end
    else if (paddr == filter_sync_pkg::ADDR_STATUS)
    begin
      rd_word[filter_sync_pkg::ST_SETTLE_BIT] = r.settle != '0;
      rd_word[filter_sync_pkg::ST_READY_BIT] = r.ready_n;
      rd_word[filter_sync_pkg::ST_FORCE_BIT] = r.force_low;
      rd_word[filter_sync_pkg::ST_ARMED_BIT] = r.armed;
      rd_word[filter_sync_pkg::ST_LEFT_LSB +: 6] = r.settle;
    end
    else if (paddr == filter_sync_pkg::ADDR_DATA)
    begin
      rd_word = r.conv_data;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  always_comb
  begin
    logic wr;
    logic pin_rise;
    logic sync_evt;
    logic aligned;
    logic resync;
    logic [15:0] phase_next;
    wr = psel & penable & pwrite;
    // Edge detector looks only past the first synchroniser flop
    pin_rise = r.sync_s2 & ~r.sync_s3;
    sync_evt = pin_rise | r.sync_cmd;
    // Compare the phase this edge lands on, so whole output periods match
    phase_next = (r.phase_cnt >= period - 16'h1) ? 16'h0 : r.phase_cnt + 16'h1;
    aligned = r.cont & r.armed & (phase_next == r.last_phase);
    resync = r.reset_cmd | (sync_evt & ~aligned);
    n = r;
    n.sync_s1 = sync_pin;
    n.sync_s2 = r.sync_s1;
    n.sync_s3 = r.sync_s2;
    n.conv_valid = 1'b0;
    n.clear = 1'b0;
    n.sync_cmd = 1'b0;
    n.reset_cmd = 1'b0;
    n.mod_cnt = r.mod_cnt + 2'h1;
    n.mod_strobe = r.mod_cnt == 2'(filter_sync_pkg::MOD_DIV - 1);
    n.phase_cnt = phase_next;

    // Ready pulses high during an update, then falls to flag new data
    if (r.high_cnt != '0)
    begin
      n.high_cnt = r.high_cnt - 3'h1;
      if (r.high_cnt == 3'h1)
        n.ready_n = 1'b0;
    end

    if (sel_valid && !resync && !r.clear)
    begin
      if (r.settle != '0)
      begin
        n.settle = r.settle - 6'h1;
        if (r.cont)
        begin
          n.conv_data = '0;
          n.conv_valid = 1'b1;
          n.force_low = 1'b1;
          n.high_cnt = filter_sync_pkg::READY_HIGH_CYCLES;
          n.ready_n = 1'b1;
        end
      end
      else
      begin
        n.conv_data = sel_data;
        n.conv_valid = 1'b1;
        n.force_low = 1'b0;
        n.high_cnt = filter_sync_pkg::READY_HIGH_CYCLES;
        n.ready_n = 1'b1;
      end
    end

    if (sync_evt && r.cont)
      n.armed = 1'b1;

    if (resync)
    begin
      n.clear = 1'b1;
      n.settle = filter_sync_pkg::SETTLE_READINGS;
      n.phase_cnt = '0;
      n.last_phase = '0;
      n.force_low = r.cont;
      if (!r.cont || r.reset_cmd)
      begin
        n.ready_n = 1'b1;
        n.high_cnt = '0;
      end
    end

    if (r.reset_cmd)
    begin
      n.path = filter_sync_pkg::PATH_RESET;
      n.rate = filter_sync_pkg::RATE_RESET;
      n.phase_min = filter_sync_pkg::PHASE_RESET;
      n.cont = filter_sync_pkg::CONT_RESET;
      n.hpcoef = filter_sync_pkg::HPCOEF_RESET;
      n.armed = 1'b0;
      n.force_low = 1'b0;
    end

    if (wr && paddr == filter_sync_pkg::ADDR_CONTROL)
    begin
      n.path = pwdata[filter_sync_pkg::CTL_PATH_LSB +: 2];
      // Reserved rate codes clamp to the fastest legal rate
      if (pwdata[filter_sync_pkg::CTL_RATE_LSB +: 3] > filter_sync_pkg::RATE_MAX_CODE)
        n.rate = filter_sync_pkg::RATE_MAX_CODE;
      else
        n.rate = pwdata[filter_sync_pkg::CTL_RATE_LSB +: 3];
      n.phase_min = pwdata[filter_sync_pkg::CTL_PHASE_BIT];
      n.cont = pwdata[filter_sync_pkg::CTL_CONT_BIT];
      n.armed = 1'b0;
    end
    else if (wr && paddr == filter_sync_pkg::ADDR_HPCOEF)
    begin
      n.hpcoef = pwdata[15:0];
    end
    else if (wr && paddr == filter_sync_pkg::ADDR_COMMAND)
    begin
      n.sync_cmd = pwdata[filter_sync_pkg::CMD_SYNC_BIT];
      n.reset_cmd = pwdata[filter_sync_pkg::CMD_RESET_BIT];
    end

    if (psel && !penable)
      n.prdata = rd_word;
  end

  // Pin reset is asynchronous and holds everything while low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= RESET_STATE;
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign mod_strobe = r.mod_strobe;
  assign sinc_rate = r.rate;
  assign conv_data = r.conv_data;
  assign conv_valid = r.conv_valid;
  assign conversion_ready_n = r.ready_n;
  assign dout_force_low = r.force_low;

endmodule : decimation_filter_sync_control

`default_nettype wire

// file: test/filter_sync_properties.sv
// Port-level properties of the filter and sync control block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`default_nettype none

module filter_sync_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed outputs
  input wire logic mod_strobe,
  input wire logic [2:0] sinc_rate,
  input wire logic [31:0] conv_data,
  input wire logic conv_valid,
  input wire logic conversion_ready_n,
  input wire logic dout_force_low
);
  timeunit 1ns;
  timeprecision 1ps;
  a_strobe_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    mod_strobe |=> !mod_strobe [*3])
    else $error("modulator strobe closer than four clocks");
  a_rate_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    sinc_rate <= 3'h4)
    else $error("sinc rate code above the largest code");
  a_ready_width: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid |-> conversion_ready_n [*4])
    else $error("ready pulse shorter than four clocks");
  a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(conversion_ready_n) |-> $past(conv_valid, 4))
    else $error("ready fell without a new word four clocks before");
  a_valid_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid |=> !conv_valid [*3])
    else $error("output words closer than the fastest path allows");
  a_forced_zero: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && dout_force_low |-> conv_data == 32'h0000_0000)
    else $error("word not zero while output is forced low");
  // No disable here: from the second edge of a held reset the outputs sit quiet
  a_reset_quiet: assert property (@(posedge pclk)
    !presetn ##1 !presetn |-> conversion_ready_n && !conv_valid && !dout_force_low)
    else $error("outputs active during reset");
  a_reset_rate: assert property (@(posedge pclk)
    !presetn ##1 !presetn |-> sinc_rate == 3'h2)
    else $error("rate code not at default during reset");
endmodule : filter_sync_properties

bind decimation_filter_sync_control filter_sync_properties chk_u (
  .pclk(pclk), .presetn(presetn), .mod_strobe(mod_strobe), .sinc_rate(sinc_rate),
  .conv_data(conv_data), .conv_valid(conv_valid),
  .conversion_ready_n(conversion_ready_n), .dout_force_low(dout_force_low)
);

`default_nettype wire

// file: test/sinc_source_model.sv
// Stand-in for the sinc stage: one word per 128>>rate modulator strobes.
// Assumes the bench supplies a fresh random word every clock.
`default_nettype none

module sinc_source_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the block
  input wire logic mod_strobe,
  input wire logic [2:0] sinc_rate,
  // Sample stream
  input wire logic [31:0] sample,
  output logic sinc_valid,
  output logic [31:0] sinc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      sinc_valid <= 1'b0;
      sinc_data <= 32'h0000_0000;
    end
    else
    begin
      sinc_valid <= 1'b0;
      // Between words the bus keeps changing so a stale word never matches
      sinc_data <= ~sinc_data;
      if (mod_strobe)
      begin
        cnt <= cnt + 8'h01;
        if (cnt >= (8'h80 >> sinc_rate) - 8'h01)
        begin
          cnt <= 8'h00;
          sinc_valid <= 1'b1;
          sinc_data <= sample;
        end
      end
    end
  end
endmodule : sinc_source_model

`default_nettype wire

// file: test/decimation_filter_sync_control_tb_top.sv
// Self-checking bench for the filter and sync control block.
// Assumes the sinc stand-in model and the bound property checker.
`default_nettype none

module decimation_filter_sync_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic mod_bit, mb_d, sinc_valid, mod_strobe, sync_pin, conv_valid;
  logic conversion_ready_n, dout_force_low;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sinc_data, conv_data, rt, q, x;
  logic [31:0] rs = 32'h0000_0007;
  logic [6:0] w;
  logic [2:0] sinc_rate;
  int failures, compares, n;

  decimation_filter_sync_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit), .sinc_valid(sinc_valid),
    .sinc_data(sinc_data), .mod_strobe(mod_strobe), .sinc_rate(sinc_rate),
    .sync_pin(sync_pin), .conv_data(conv_data), .conv_valid(conv_valid),
    .conversion_ready_n(conversion_ready_n), .dout_force_low(dout_force_low));
  sinc_source_model src_u (.pclk(pclk), .presetn(presetn), .mod_strobe(mod_strobe),
    .sinc_rate(sinc_rate), .sample(rs), .sinc_valid(sinc_valid), .sinc_data(sinc_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [31:0] exp_ctl(input logic [6:0] v);
    logic [2:0] r;
    r = (v[4:2] > filter_sync_pkg::RATE_MAX_CODE) ? filter_sync_pkg::RATE_MAX_CODE : v[4:2];
    return {25'h0, v[6:5], r, v[1:0]};
  endfunction : exp_ctl

  task automatic chk(input string nm, input logic [31:0] xe, input logic [31:0] g);
    compares++;
    if (g !== xe)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, xe, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic gap(input int lim);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (conv_valid !== 1'b1 && n < lim);
  endtask : gap

  // Sync pin edge, status read, then edge-to-edge spacing of sp clocks
  task automatic pulse(input int sp);
    sync_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    sync_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, filter_sync_pkg::ADDR_STATUS, 32'h0);
    repeat (sp - 7) @(posedge pclk);
  endtask : pulse

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    rs <= xs(rs);
    mod_bit <= rs[9];
    mb_d <= mod_bit;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, sync_pin} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rt = 32'h0000_0007;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, filter_sync_pkg::ADDR_CONTROL, 32'h0);
    chk("control", 32'h0000_000A, q);
    apb(1'b0, filter_sync_pkg::ADDR_HPCOEF, 32'h0);
    chk("hpcoef", 32'h0000_0337, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int c = 0; c < 8; c++)
    begin
      rt = xs(rt);
      w = {rt[6:5], c[2:0], rt[1:0]};
      x = exp_ctl(w);
      apb(1'b1, filter_sync_pkg::ADDR_CONTROL, {25'h0, w});
      apb(1'b0, filter_sync_pkg::ADDR_CONTROL, 32'h0);
      chk("control", x, q);
      chk("sinc rate", {29'h0, x[4:2]}, {29'h0, sinc_rate});
      apb(1'b1, filter_sync_pkg::ADDR_HPCOEF, rt);
      apb(1'b0, filter_sync_pkg::ADDR_HPCOEF, 32'h0);
      chk("hpcoef", {16'h0, rt[15:0]}, q);
    end
    // Pin reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("ready in reset", 32'h1, {31'h0, conversion_ready_n});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, filter_sync_pkg::ADDR_CONTROL, 32'h0);
    chk("control", 32'h0000_000A, q);
    // Pulse sync on the bypass path, from the pin and then by command
    apb(1'b1, filter_sync_pkg::ADDR_CONTROL, 32'h0000_0010);
    for (int s = 0; s < 2; s++)
    begin
      gap(400);
      if (s == 0)
        pulse(8);
      else
        apb(1'b1, filter_sync_pkg::ADDR_COMMAND, 32'h1);
      repeat (4) @(posedge pclk);
      n = 0;
      repeat (190) @(posedge pclk) n += (conv_valid !== 1'b0 || conversion_ready_n !== 1'b1);
      chk("quiet", 32'h0, n);
      gap(120);
      chk("settled", 32'h1, {31'h0, conv_valid});
      gap(10);
      chk("bypass period", 32'h4, n);
      chk("bypass word", {31'h0, mb_d}, conv_data);
    end
    // Continuous mode on the bypass path
    apb(1'b1, filter_sync_pkg::ADDR_CONTROL, 32'h0000_0050);
    pulse(100);
    chk("first edge", 32'h1, {31'h0, q[13:8] >= 6'h3C});
    chk("forced", 32'h1, {31'h0, q[2]});
    pulse(102);
    chk("match", 32'h1, {31'h0, q[13:8] < 6'h3C});
    pulse(100);
    chk("mismatch", 32'h1, {31'h0, q[13:8] >= 6'h3C});
    // FIR and FIR plus high-pass, random phase, continuous mode
    for (int p = 2; p < 4; p++)
    begin
      rt = xs(rt);
      apb(1'b1, filter_sync_pkg::ADDR_HPCOEF, {16'h0, rt[15:0]});
      apb(1'b1, filter_sync_pkg::ADDR_CONTROL, {25'h0, 1'b1, rt[20], 3'b100, p[1:0]});
      pulse(20);
      gap(3000);
      gap(1100);
      chk("fir period", 32'h400, n);
      chk("forced", 32'h1, {31'h0, dout_force_low});
      chk("forced word", 32'h0, conv_data);
    end
    // Reset command returns defaults
    apb(1'b1, filter_sync_pkg::ADDR_COMMAND, 32'h2);
    apb(1'b0, filter_sync_pkg::ADDR_CONTROL, 32'h0);
    chk("control", 32'h0000_000A, q);
    apb(1'b0, filter_sync_pkg::ADDR_STATUS, 32'h0);
    chk("settling", 32'h1, {31'h0, q[0]});
    wrap_up();
  end
endmodule : decimation_filter_sync_control_tb_top

`default_nettype wire
